/* File: hdl/ssac_pkg.sv */
// Package for the sleep/sync/alert control block: states, timing constants.
// Assumes a single 125 MHz system clock.
package ssac_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CLK_NS = 8;
   // Least low time on the wake input, in ns
   localparam int unsigned WAKE_LOW_NS = 5000;
   localparam int unsigned WAKE_LOW_CYC = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
   // Sync wait timeout, in ms
   localparam int unsigned SYNC_WAIT_MS = 100;
   localparam int unsigned SYNC_WAIT_CYC = SYNC_WAIT_MS * (CLK_HZ / 1000);
   // Abandon-sleep reset timeout, in ms
   localparam int unsigned SLEEP_FAIL_MS = 2000;
   localparam int unsigned SLEEP_FAIL_CYC = SLEEP_FAIL_MS * (CLK_HZ / 1000);
   localparam int unsigned NUM_KEYS = 16;
   localparam int unsigned LAST_KEY = 15;
   // Sleep command and acknowledge character
   localparam logic [7:0] SLEEP_CHAR = 8'h5a;
   localparam logic [7:0] NULL_CHAR = 8'h00;
   localparam logic [15:0] SCOPE_SEL_RST = 16'h0000;
   typedef enum logic [2:0] {
      SSAC_RUN, SSAC_DRAIN, SSAC_ACK, SSAC_WAIT_SS, SSAC_SLEEP, SSAC_WAKE_ACK
   } ssac_pwr_t;
   typedef enum logic [1:0] {SSAC_SCAN, SSAC_HOLD, SSAC_GO} ssac_scan_t;
endpackage

/* File: hdl/ssac_wake_filter.sv */
// Wake input conditioner: two-stage synchroniser, edge detect, low-time filter.
// Assumes the caller keeps the filter enabled only while the device is asleep.
`timescale 1ns/10ps
module ssac_wake_filter #(
   parameter int unsigned LOW_CYC = 625
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_in,
   input wire logic filt_en,
   output logic level_sync,
   output logic fall_pulse,
   output logic wake_pulse
);
   import ssac_pkg::*;
   initial begin
      if (LOW_CYC < 1 || LOW_CYC > 65535) $error("LOW_CYC out of range");
   end
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic [15:0] low_cnt_reg;

   // Two flops; the first is read only by the second to keep metastability contained
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   assign level_sync = sync_reg;
   assign fall_pulse = prev_reg & ~sync_reg; // see R21

   // Count low time; a short glitch restarts the count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_reg <= 16'h0000;
      end else if (!filt_en || sync_reg) begin
         low_cnt_reg <= 16'h0000;
      end else if (low_cnt_reg != 16'(LOW_CYC)) begin
         low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
   end
   assign wake_pulse = filt_en && !sync_reg && (low_cnt_reg == 16'(LOW_CYC - 1)); // see R03
endmodule

/* File: hdl/ssac_top.sv */
// Sleep/wake, noise sync, alert and scope-sync control of a touch-key controller.
// Assumes command decode, burst engine and byte transmitter live outside.
// Contract
// R01 - Sleep command waits for any running burst to end before sleeping.
// R02 - Host drives the wake input high right after the sleep command.
// R03 - Wake when the wake input stays low at least 5 us.
// R04 - A null command byte that caused the wake is discarded.
// R05 - Clock gated off in sleep; operation resumes without recalibration.
// R06 - Sleep character sent as acknowledge just before sleeping.
// R07 - Another sleep character sent after waking.
// R08 - In slave-only SPI, host raises slave select after the acknowledge.
// R09 - If slave select stays low, abandon sleep and full reset after 2 s.
// R10 - Sync and sleep coexist; a sync edge also wakes the device. Here only a 5 us low wakes it; a falling edge alone does not.
// R11 - A configuration command enables or disables sync mode.
// R12 - Wait before key 0 only, up to 100 ms; falling edge starts scan.
// R13 - Without sync edge, next scan starts 100 ms after the previous ends.
// R14 - Alert output held low while any key calibrates.
// R15 - Alert pulses low for each detected key's burst, else high.
// R16 - Alert driven low while any key error is present.
// R17 - Alert asserted at sleep entry stays asserted through sleep.
// R18 - Host watches alert falling edge, polls keys afterwards.
// R19 - Scope-sync pulses high over bursts of selected keys.
// R20 - Scope-sync selection is volatile, cleared by any reset.
// R21 - Wake input synchronised; only high-to-low counts as sync event.
`timescale 1ns/10ps
module ssac_top #(
   parameter int unsigned SYNC_WAIT = ssac_pkg::SYNC_WAIT_CYC,
   parameter int unsigned SLEEP_FAIL = ssac_pkg::SLEEP_FAIL_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wake_sync_input,
   input wire logic spi_slave_only,
   input wire logic ss_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic sync_cfg_valid,
   input wire logic sync_cfg_en,
   input wire logic scope_cfg_valid,
   input wire logic [15:0] scope_cfg_mask,
   input wire logic burst_active,
   input wire logic burst_done,
   input wire logic [3:0] burst_key,
   input wire logic key_detect,
   input wire logic cal_any,
   input wire logic err_any,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic scan_start,
   output logic run_en,
   output logic osc_gate_n,
   output logic cmd_discard,
   output logic reset_req,
   output logic alert_indicator_output_n,
   output logic scope_sync_output
);
   import ssac_pkg::*;
   initial begin
      if (SYNC_WAIT < 1 || SLEEP_FAIL < 1) $error("Timeout parameters must be nonzero");
   end

   ssac_pwr_t pwr_reg;
   ssac_scan_t scan_reg;
   logic sync_en_reg;
   logic [15:0] scope_mask_reg;
   logic [31:0] wait_cnt_reg;
   logic [31:0] fail_cnt_reg;
   logic alert_hold_reg;
   logic alert_reg;
   logic scope_reg;
   logic wake_by_null_reg;
   logic ws_level;
   logic ws_fall;
   logic ws_wake;
   logic sleep_cmd;
   logic asleep;

   assign sleep_cmd = cmd_valid && (cmd_byte == SLEEP_CHAR) && (pwr_reg == SSAC_RUN);
   assign asleep = (pwr_reg == SSAC_SLEEP);

   // Filter runs only while asleep so a wake needs a fresh low period
   ssac_wake_filter #(
      .LOW_CYC(WAKE_LOW_CYC)
   ) u_filt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(wake_sync_input),
      .filt_en(asleep),
      .level_sync(ws_level),
      .fall_pulse(ws_fall),
      .wake_pulse(ws_wake)
   );

   // Sync mode configuration
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_en_reg <= 1'b0;
      end else if (sync_cfg_valid) begin
         sync_en_reg <= sync_cfg_en; // see R11
      end
   end

   // Scope selection lives only in flops, so every reset clears it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scope_mask_reg <= SCOPE_SEL_RST; // see R20
      end else if (scope_cfg_valid) begin
         scope_mask_reg <= scope_cfg_mask;
      end
   end

   // Power sequencing: drain burst, acknowledge, check select, sleep, notify
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwr_reg <= SSAC_RUN;
      end else begin
         unique case (pwr_reg)
            SSAC_RUN: begin
               if (sleep_cmd) begin
                  pwr_reg <= SSAC_DRAIN;
               end
            end
            SSAC_DRAIN: begin
               if (!burst_active) begin
                  pwr_reg <= SSAC_ACK; // see R01
               end
            end
            SSAC_ACK: begin
               if (tx_ready) begin
                  pwr_reg <= spi_slave_only ? SSAC_WAIT_SS : SSAC_SLEEP; // see R06
               end
            end
            SSAC_WAIT_SS: begin
               if (ss_n) begin
                  pwr_reg <= SSAC_SLEEP; // see R08
               end else if (fail_cnt_reg == 32'(SLEEP_FAIL - 1)) begin
                  pwr_reg <= SSAC_RUN; // see R09
               end
            end
            SSAC_SLEEP: begin
               if (ws_wake) begin
                  pwr_reg <= SSAC_WAKE_ACK; // see R03 R10
               end
            end
            SSAC_WAKE_ACK: begin
               if (tx_ready) begin
                  pwr_reg <= SSAC_RUN; // see R07
               end
            end
            default: pwr_reg <= SSAC_RUN;
         endcase
      end
   end

   // Select timeout counter; abandoning sleep raises a full reset request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fail_cnt_reg <= 32'h0000_0000;
         reset_req <= 1'b0;
      end else begin
         reset_req <= (pwr_reg == SSAC_WAIT_SS) && !ss_n
            && (fail_cnt_reg == 32'(SLEEP_FAIL - 1)); // see R09
         if (pwr_reg == SSAC_WAIT_SS && !ss_n) begin
            fail_cnt_reg <= fail_cnt_reg + 32'h0000_0001;
         end else begin
            fail_cnt_reg <= 32'h0000_0000;
         end
      end
   end

   // A null byte arriving while asleep, during the wake notice or as the first command after waking is dropped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_by_null_reg <= 1'b0;
      end else if (asleep && ws_wake) begin
         wake_by_null_reg <= 1'b1;
      end else if (pwr_reg == SSAC_RUN && cmd_valid) begin
         wake_by_null_reg <= 1'b0;
      end
   end
   assign cmd_discard = cmd_valid && (cmd_byte == NULL_CHAR)
      && (asleep || pwr_reg == SSAC_WAKE_ACK || wake_by_null_reg); // see R04

   // Acknowledge and wake-notice bytes; state held, not reset, across sleep
   assign tx_valid = (pwr_reg == SSAC_ACK) || (pwr_reg == SSAC_WAKE_ACK);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte <= 8'h00;
      end else begin
         tx_byte <= SLEEP_CHAR; // see R06 R07
      end
   end

   // Gate the oscillator in sleep; scan state is kept so work resumes in place
   assign osc_gate_n = !asleep && (pwr_reg != SSAC_WAIT_SS); // see R05
   assign run_en = (pwr_reg == SSAC_RUN) && (scan_reg == SSAC_GO);

   // Scan gating before key 0: wait for a falling sync edge or the 100 ms timeout
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scan_reg <= SSAC_GO;
         wait_cnt_reg <= 32'h0000_0000;
      end else begin
         unique case (scan_reg)
            SSAC_GO: begin
               wait_cnt_reg <= 32'h0000_0000;
               if (burst_done && burst_key == 4'(LAST_KEY) && sync_en_reg) begin
                  scan_reg <= SSAC_HOLD; // see R12
               end
            end
            SSAC_HOLD: begin
               if (!sync_en_reg || ws_fall) begin
                  scan_reg <= SSAC_SCAN; // see R12 R21
               end else if (wait_cnt_reg == 32'(SYNC_WAIT - 1)) begin
                  scan_reg <= SSAC_SCAN; // see R13
               end else if (!asleep) begin
                  wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
               end
            end
            SSAC_SCAN: begin
               scan_reg <= SSAC_GO;
            end
            default: scan_reg <= SSAC_GO;
         endcase
      end
   end
   assign scan_start = (scan_reg == SSAC_SCAN);

   // One decision for what pulls the alert low, shared by the live and held copies
   function automatic logic alert_cause(input logic cal, input logic err, input logic hit);
      return cal || err || hit;
   endfunction

   // Alert: calibration, errors and detected-key bursts pull low; frozen in sleep
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alert_reg <= 1'b0;
         alert_hold_reg <= 1'b0;
      end else if (asleep) begin
         alert_reg <= alert_hold_reg; // see R17
      end else begin
         alert_reg <= alert_cause(cal_any, err_any, burst_active && key_detect); // see R14 R15 R16
         alert_hold_reg <= alert_cause(cal_any, err_any, burst_active && key_detect);
      end
   end
   assign alert_indicator_output_n = !alert_reg;

   // Scope sync brackets each burst whose key is selected
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scope_reg <= 1'b0;
      end else begin
         scope_reg <= burst_active && scope_mask_reg[burst_key]; // see R19
      end
   end
   assign scope_sync_output = scope_reg;

   sequence s_drain;
      (pwr_reg == SSAC_DRAIN) && burst_active;
   endsequence
   sequence s_ack;
      pwr_reg == SSAC_ACK;
   endsequence

   a_drain_before_ack: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R01
      s_drain |=> pwr_reg != SSAC_ACK || !$past(burst_active))
      else $error("Acknowledge while burst active");
   a_ack_then_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R06
      s_ack and tx_ready and !spi_slave_only |=> asleep)
      else $error("No sleep after acknowledge");
   a_wake_low_time: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R03
      asleep && ws_wake |-> !ws_level ##1 pwr_reg == SSAC_WAKE_ACK)
      else $error("Wake without low level");
   a_wake_notice: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R07
      pwr_reg == SSAC_WAKE_ACK |-> tx_valid && tx_byte == SLEEP_CHAR)
      else $error("Wake notice not sent");
   a_fail_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R09
      reset_req |-> pwr_reg == SSAC_RUN && $past(pwr_reg) == SSAC_WAIT_SS)
      else $error("Reset request without select timeout");
   a_sync_edge_go: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R12
      scan_reg == SSAC_HOLD && sync_en_reg && ws_fall |=> scan_start ##1 run_en || asleep)
      else $error("Sync edge did not start scan");
   a_alert_cal: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R14
      !asleep && cal_any |=> !alert_indicator_output_n)
      else $error("Alert high during calibration");
   a_alert_err: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R16
      !asleep && err_any |=> !alert_indicator_output_n)
      else $error("Alert high with key error");
   a_alert_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R17
      asleep && $past(asleep) |-> $stable(alert_indicator_output_n))
      else $error("Alert changed in sleep");
   a_scope_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R19
      burst_active && scope_mask_reg[burst_key] |=> scope_sync_output)
      else $error("Scope pulse missing");
   a_null_drop: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R04
      asleep && cmd_valid && cmd_byte == NULL_CHAR |-> cmd_discard)
      else $error("Wake null not discarded");

   sequence s_sleep_taken;
      (pwr_reg == SSAC_ACK) && tx_ready;
   endsequence
   sequence s_select_lost;
      (pwr_reg == SSAC_WAIT_SS) && !ss_n && (fail_cnt_reg == 32'(SLEEP_FAIL - 1));
   endsequence
   sequence s_sync_timeout;
      (scan_reg == SSAC_HOLD) && sync_en_reg && !ws_fall
         && (wait_cnt_reg == 32'(SYNC_WAIT - 1));
   endsequence

   // Handshake outputs must stand until taken, and pulses must last one cycle
   a_reply_stands: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R06
      tx_valid && !tx_ready |=> tx_valid)
      else $error("Reply byte dropped before taken");
   a_no_early_ack: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R01
      s_drain |=> !tx_valid)
      else $error("Reply offered during burst");
   a_select_wait: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R08
      s_sleep_taken ##0 spi_slave_only |=> pwr_reg == SSAC_WAIT_SS)
      else $error("Select not awaited in slave-only mode");
   a_select_lost: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R09
      s_select_lost |=> reset_req && pwr_reg == SSAC_RUN)
      else $error("Select timeout did not abandon sleep");
   a_reset_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R09
      reset_req |=> !reset_req)
      else $error("Reset request longer than one cycle");
   a_sync_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R13
      s_sync_timeout |=> scan_start)
      else $error("Sync wait did not time out");
   a_hold_stops: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R12
      scan_reg == SSAC_HOLD |-> !run_en && !scan_start)
      else $error("Scan running while waiting for sync");
   a_scan_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R12
      scan_start |=> !scan_start)
      else $error("Scan start longer than one cycle");
   a_alert_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R15
      !asleep && !alert_cause(cal_any, err_any, burst_active && key_detect)
         |=> alert_indicator_output_n)
      else $error("Alert low without cause");
   a_scope_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R19
      !burst_active |=> !scope_sync_output)
      else $error("Scope pulse outside burst");
   a_osc_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R05
      asleep |-> !osc_gate_n && !run_en)
      else $error("Clock or scan running in sleep");
   a_discard_null: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R04
      cmd_discard |-> cmd_byte == NULL_CHAR)
      else $error("Non-null byte discarded");
endmodule

/* File: dv/ssac_host_model.sv */
// Host model: takes reply bytes, drives the wake/sync line and slave select.
// Assumes the bench steers it through wake_req, ss_keep_low and slow.
`timescale 1ns/10ps
module ssac_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic wake_req,
   input wire logic ss_keep_low,
   input wire logic slow,
   input wire logic alert_n,
   output logic wake_sync_input,
   output logic ss_n,
   output logic tx_ready,
   output logic [7:0] last_byte,
   output logic [7:0] byte_cnt,
   output logic [7:0] alert_falls
);
   logic [1:0] wait_reg;
   logic alert_prev;
   // Host interrupt on the alert line: count falling edges of alert_n
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alert_prev <= 1'b1;
         alert_falls <= 8'h00;
      end else begin
         alert_prev <= alert_n;
         if (alert_prev && !alert_n) begin
            alert_falls <= alert_falls + 8'h01;
         end
      end
   end
   // Line is pulled high unless asked low; a sleeping device must see high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_sync_input <= 1'b1;
      end else begin
         wake_sync_input <= ~wake_req;
      end
   end
   // Fetch a reply byte; slow mode takes four cycles to answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         ss_n <= 1'b1;
         wait_reg <= 2'h0;
         last_byte <= 8'h00;
         byte_cnt <= 8'h00;
      end else if (tx_valid && tx_ready) begin
         tx_ready <= 1'b0;
         wait_reg <= 2'h0;
         last_byte <= tx_byte;
         byte_cnt <= byte_cnt + 8'h01;
         ss_n <= !ss_keep_low;
      end else if (tx_valid) begin
         ss_n <= 1'b0;
         wait_reg <= wait_reg + 2'h1;
         tx_ready <= !slow || wait_reg == 2'h3;
      end else if (!ss_keep_low) begin
         ss_n <= 1'b1;
      end
   end
endmodule

/* File: dv/ssac_top_test.sv */
// Testbench for the sleep/sync/alert control block.
// Assumes a 125 MHz clock and shortened sync and sleep-fail counts.
`timescale 1ns/10ps
module ssac_top_test;
   import ssac_pkg::*;
   localparam int unsigned SW = 50;
   localparam int unsigned SF = 40;
   logic clk_sys, rst_n = 1'b0, spi_slave_only = 1'b0, cmd_valid = 1'b0;
   logic [7:0] cmd_byte = 8'h00;
   logic sync_cfg_valid = 1'b0, sync_cfg_en = 1'b0, scope_cfg_valid = 1'b0;
   logic [15:0] scope_cfg_mask = 16'h0000;
   logic burst_active = 1'b0, burst_done = 1'b0, key_detect = 1'b0;
   logic [3:0] burst_key = 4'h0;
   logic cal_any = 1'b0, err_any = 1'b0, wake_req = 1'b0, ss_keep_low = 1'b0;
   logic slow = 1'b0, wake_sync_input, ss_n, tx_ready, tx_valid, scan_start;
   logic run_en, osc_gate_n, cmd_discard, reset_req;
   logic alert_indicator_output_n, scope_sync_output;
   logic [7:0] tx_byte, last_byte, byte_cnt, alert_falls;
   int err_count = 0;
   int compares = 0;
   ssac_top #(.SYNC_WAIT(SW), .SLEEP_FAIL(SF)) i_ssac_top (.clk_sys, .rst_n,
      .wake_sync_input, .spi_slave_only, .ss_n, .cmd_valid, .cmd_byte,
      .sync_cfg_valid, .sync_cfg_en, .scope_cfg_valid, .scope_cfg_mask,
      .burst_active, .burst_done, .burst_key, .key_detect, .cal_any, .err_any,
      .tx_ready, .tx_valid, .tx_byte, .scan_start, .run_en, .osc_gate_n,
      .cmd_discard, .reset_req, .alert_indicator_output_n, .scope_sync_output);
   ssac_host_model i_ssac_host_model (.clk_sys, .rst_n, .tx_valid, .tx_byte,
      .wake_req, .ss_keep_low, .slow, .wake_sync_input, .ss_n, .tx_ready,
      .last_byte, .byte_cnt, .alert_n(alert_indicator_output_n), .alert_falls);
   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Bounded wait: 0 reply, 1 scan start, 2 reset request, 3 clock gated
   task automatic wait_on(input int sel, input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(negedge clk_sys);
         if ((sel == 0 && tx_valid === 1'b1) || (sel == 1 && scan_start === 1'b1) ||
               (sel == 2 && reset_req === 1'b1) || (sel == 3 && osc_gate_n === 1'b0)) begin
            break;
         end
      end
      if (n == lim) begin
         err_count++;
         $display("unexpected timeout: expected event %0d, seen none", sel);
         print_verdict();
      end
   endtask
   task automatic send_cmd(input logic [7:0] b, input logic disc);
      @(posedge clk_sys);
      cmd_byte <= b;
      cmd_valid <= 1'b1;
      @(negedge clk_sys);
      check("discard", cmd_discard, disc);
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
   task automatic wake_up();
      int n;
      @(posedge clk_sys);
      wake_req <= 1'b1;
      wait_on(0, 700, n);
      check("wake low time met", n >= 620, 1'b1);
      check("wake notice", tx_byte, SLEEP_CHAR);
      @(posedge clk_sys);
      wake_req <= 1'b0;
      tick(10);
      check("awake clock", osc_gate_n, 1'b1);
      check("awake run", run_en, 1'b1);
      check("wake byte", last_byte, SLEEP_CHAR);
   endtask
   task automatic t_reset();
      tick(1);
      check("reset alert", alert_indicator_output_n, 1'b1);
      check("reset scope", scope_sync_output, 1'b0);
      check("reset reply", tx_valid, 1'b0);
      check("reset clock", osc_gate_n, 1'b1);
   endtask
   task automatic t_sleep_wake();
      int n;
      logic [7:0] b0;
      b0 = byte_cnt;
      send_cmd(SLEEP_CHAR, 1'b0);
      wait_on(0, 10, n);
      check("sleep ack", tx_byte, SLEEP_CHAR);
      wait_on(3, 20, n);
      check("acks taken", byte_cnt, b0 + 8'h01);
      send_cmd(NULL_CHAR, 1'b1);
      @(posedge clk_sys);
      wake_req <= 1'b1;
      repeat (300) @(posedge clk_sys);
      wake_req <= 1'b0;
      tick(20);
      check("short low ignored", osc_gate_n, 1'b0);
      wake_up();
      check("byte count", byte_cnt, b0 + 8'h02);
   endtask
   // Sleep held off by a running burst, with a slow host
   task automatic t_burst_sleep();
      int n;
      @(posedge clk_sys);
      burst_active <= 1'b1;
      slow <= 1'b1;
      send_cmd(SLEEP_CHAR, 1'b0);
      tick(8);
      check("no ack in burst", tx_valid, 1'b0);
      @(posedge clk_sys);
      burst_active <= 1'b0;
      wait_on(0, 5, n);
      wait_on(3, 20, n);
      wake_up();
      slow <= 1'b0;
   endtask
   task automatic t_select();
      int n;
      @(posedge clk_sys);
      spi_slave_only <= 1'b1;
      ss_keep_low <= 1'b1;
      send_cmd(SLEEP_CHAR, 1'b0);
      wait_on(2, SF + 20, n);
      check("fail delay", n >= SF - 5, 1'b1);
      tick(2);
      check("run after fail", osc_gate_n, 1'b1);
      check("reset pulse", reset_req, 1'b0);
      ss_keep_low <= 1'b0;
      send_cmd(SLEEP_CHAR, 1'b0);
      wait_on(3, 20, n);
      wake_up();
      @(posedge clk_sys);
      spi_slave_only <= 1'b0;
   endtask
   task automatic end_scan();
      @(posedge clk_sys);
      burst_key <= 4'hf;
      burst_done <= 1'b1;
      @(posedge clk_sys);
      burst_done <= 1'b0;
   endtask
   task automatic cfg_sync(input logic e);
      @(posedge clk_sys);
      sync_cfg_en <= e;
      sync_cfg_valid <= 1'b1;
      @(posedge clk_sys);
      sync_cfg_valid <= 1'b0;
   endtask
   task automatic t_sync();
      int n;
      wake_req <= 1'b1;
      cfg_sync(1'b1);
      tick(4);
      end_scan();
      tick(3);
      check("hold before key 0", run_en, 1'b0);
      wake_req <= 1'b0;
      tick(10);
      check("rising edge ignored", run_en, 1'b0);
      wake_req <= 1'b1;
      wait_on(1, 8, n);
      tick(2);
      check("scan resumed", run_en, 1'b1);
      check("scan pulse", scan_start, 1'b0);
      wake_req <= 1'b0;
      end_scan();
      wait_on(1, SW + 10, n);
      check("sync timeout", n >= SW - 3, 1'b1);
      cfg_sync(1'b0);
      end_scan();
      tick(3);
      check("sync off", run_en, 1'b1);
   endtask
   task automatic set_alert(input logic c, input logic e, input logic a, input logic d,
         input logic exp);
      @(posedge clk_sys);
      cal_any <= c;
      err_any <= e;
      burst_key <= 4'h5;
      burst_active <= a;
      key_detect <= d;
      tick(2);
      check("alert", alert_indicator_output_n, exp);
   endtask
   task automatic t_alert();
      int n;
      logic [7:0] f0;
      f0 = alert_falls;
      set_alert(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      set_alert(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      set_alert(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      set_alert(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      set_alert(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      set_alert(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      send_cmd(SLEEP_CHAR, 1'b0);
      wait_on(3, 20, n);
      set_alert(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wake_up();
      check("alert after wake", alert_indicator_output_n, 1'b1);
      check("alert falls", alert_falls, f0 + 8'h02);
   endtask
   task automatic t_scope();
      @(posedge clk_sys);
      scope_cfg_mask <= 16'h0018;
      scope_cfg_valid <= 1'b1;
      @(posedge clk_sys);
      scope_cfg_valid <= 1'b0;
      for (int k = 2; k < 6; k++) begin
         @(posedge clk_sys);
         burst_key <= 4'(k);
         burst_active <= 1'b1;
         tick(2);
         check("scope in burst", scope_sync_output, k == 3 || k == 4);
         @(posedge clk_sys);
         burst_active <= 1'b0;
         tick(2);
         check("scope idle", scope_sync_output, 1'b0);
      end
      @(posedge clk_sys);
      rst_n <= 1'b0;
      tick(2);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      burst_key <= 4'h3;
      burst_active <= 1'b1;
      tick(3);
      check("scope after reset", scope_sync_output, 1'b0);
      check("alert after reset", alert_indicator_output_n, 1'b1);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_sleep_wake();
      t_burst_sleep();
      t_select();
      t_sync();
      t_alert();
      t_scope();
      print_verdict();
   end
endmodule
